// [design/imf_cfg.svh]
/*
  Constants for the lane framer and its user-side controller: word layout,
  metaframe positions, timing counts and the controller register map.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef IMF_CFG_SVH
`define IMF_CFG_SVH

// Clock and timing
`define IMF_CLK_NS          10
`define IMF_DLL_LOCK_NS     100
`define IMF_DLL_LOCK_CYC    ((`IMF_DLL_LOCK_NS + `IMF_CLK_NS - 1) / `IMF_CLK_NS)
`define IMF_DLL_CNT_W       8
`define IMF_STRETCH         2'h3
`define IMF_HOLD_CYC        5

// Metaframe: 16 words, control word and payload slot positions, read lead and apply count
`define IMF_POS_W           4
`define IMF_POS_SYNC        4'h0
`define IMF_POS_SCRAM       4'h1
`define IMF_POS_SKIP        4'h2
`define IMF_POS_PL_FIRST    4'h3
`define IMF_POS_PL_LAST     4'he
`define IMF_POS_DIAG        4'hf
`define IMF_POS_PL_LEAD     4'h2
`define IMF_APPLY_AT        4'h8

// Sync headers, normal and corrupted
`define IMF_HDR_DATA        2'h1
`define IMF_HDR_CTRL        2'h2
`define IMF_HDR_ERR_CTRL    2'h0
`define IMF_HDR_ERR_DATA    2'h3

// Control word contents
`define IMF_SYNC_WORD       64'h78f6_78f6_78f6_78f6
`define IMF_SCRAM_WORD      64'h2800_0000_0000_0000
`define IMF_SKIP_WORD       64'h1e1e_1e1e_1e1e_1e1e
`define IMF_DIAG_TAG        30'h1900_0000
`define IMF_CRC_POLY        32'h1edc_6f41
`define IMF_CRC_INIT        32'hffff_ffff

// Frame synchroniser thresholds
`define IMF_LOCK_GOOD       3'h4
`define IMF_LOSE_BAD        3'h4

// Controller register map
`define IMF_ADDR_W          4
`define IMF_REG_CTRL        4'h0
`define IMF_REG_STATUS      4'h4
`define IMF_REG_IRQ_STAT    4'h8
`define IMF_REG_IRQ_MASK    4'hc
`define IMF_CTRL_BURST      0
`define IMF_CTRL_LANE_OK    1
`define IMF_CTRL_LINK_OK    2
`define IMF_CTRL_SIMPLE     3
`define IMF_CTRL_CRC_ERR    4
`define IMF_CTRL_ERR_INS    5
`define IMF_CTRL_RST        32'h0000_0001
`define IMF_IRQ_CRC         0
`define IMF_IRQ_LOCK_UP     1
`define IMF_IRQ_LOCK_DOWN   2

`endif

// [design/imf_pkg.sv]
/*
  Types shared by the lane framer and the controller, and the CRC step.
  Assumes imf_cfg.svh is available on the include path.
*/
`include "imf_cfg.svh"

package imf_pkg;

  typedef logic [63:0] imf_word_t;

  typedef enum logic [1:0] {
    IMF_HUNT,
    IMF_VERIFY,
    IMF_LOCKED
  } imf_sync_state_e;

  // One 64-bit word folded into a running CRC32, msb first
  function automatic logic [31:0] imf_crc_step(input logic [31:0] c, input imf_word_t d);
    logic [31:0] r;
    r = c;
    for (int i = 63; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `IMF_CRC_POLY : 32'h0000_0000);
    end
    return r;
  endfunction : imf_crc_step

endpackage : imf_pkg

// [design/imf_user_if.sv]
/*
  Per-lane framing control interface between the lane framer and user logic.
  Assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/1ps

interface imf_user_if;
  logic                tx_frame;
  logic                tx_dll_lock;
  logic                tx_pl_rd;
  imf_pkg::imf_word_t  tx_pl_data;
  logic                tx_pl_ctrl;
  logic                tx_err_ins;
  logic [1:0]          tx_diag_status;
  logic                tx_burst_en;
  logic                cfg_simple_if;
  logic                cfg_crc_err_en;
  logic                rx_frame;
  logic                rx_frame_lock;
  logic [1:0]          rx_diag_status;
  logic                rx_metaframe_crc_error;
  imf_pkg::imf_word_t  rx_pl_data;
  logic                rx_pl_valid;

  modport dev (
    output tx_frame, tx_dll_lock, tx_pl_rd,
    input  tx_pl_data, tx_pl_ctrl, tx_err_ins, tx_diag_status, tx_burst_en,
    input  cfg_simple_if, cfg_crc_err_en,
    output rx_frame, rx_frame_lock, rx_diag_status, rx_metaframe_crc_error, rx_pl_data, rx_pl_valid
  );

  modport usr (
    input  tx_frame, tx_dll_lock, tx_pl_rd,
    output tx_pl_data, tx_pl_ctrl, tx_err_ins, tx_diag_status, tx_burst_en,
    output cfg_simple_if, cfg_crc_err_en,
    input  rx_frame, rx_frame_lock, rx_diag_status, rx_metaframe_crc_error, rx_pl_data, rx_pl_valid
  );
endinterface : imf_user_if

// [design/imf_lane_framer.sv]
/*
  Per-lane metaframe framer: transmit frame generator with diagnostic word,
  burst gating, header/CRC error insertion; receive frame synchroniser with
  lock, diagnostic capture and CRC check.
  Assumes one word per clock on transmit, words qualified by valid on receive,
  and a user end on imf_user_if.usr sharing the clock.
*/
// Functional notes
// - Tx frame start high three cycles
// - Error insert corrupts header in simple mode
// - Corrupt header 00 control, 11 data
// - CRC error inverts word fed to CRC
// - Generator's own control words never corrupted
// - CRC option on: header and CRC both
// - User watches tx DLL lock output
// - Tx lane status into diag bits 33:32
// - User holds status five cycles around start
// - Status bit1 lane ok, bit0 link ok
// - Burst enable sampled once per metaframe
// - Burst off: no reads, SKIP payload
// - User holds burst five cycles around start
// - Rx frame start stretched per metaframe
// - Rx lock registered from locked state, not stretched
// - Capture diag bits 33:32 when locked
// - CRC mismatch flagged three cycles at end
`timescale 1ns/1ps
`include "imf_cfg.svh"

module imf_lane_framer (
  input  wire logic                clock,
  input  wire logic                rst_n,
  imf_user_if.dev                  usr,
  output      logic [1:0]          lane_tx_hdr,
  output      imf_pkg::imf_word_t  lane_tx_data,
  input  wire logic                lane_rx_valid,
  input  wire logic [1:0]          lane_rx_hdr,
  input  wire imf_pkg::imf_word_t  lane_rx_data
);

  logic [`IMF_POS_W-1:0]     pos_q;
  logic [`IMF_POS_W-1:0]     lead_pos;
  logic                      burst_q;
  logic [31:0]               crc_q;
  logic [1:0]                frame_cnt_q;
  logic [`IMF_DLL_CNT_W-1:0] dll_cnt_q;
  logic [1:0]                hdr_d;
  imf_pkg::imf_word_t        word_d;
  imf_pkg::imf_word_t        crc_in;
  logic                      ins_hdr;
  logic                      ins_crc;

  // Transmit position walks the metaframe continuously
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pos_q <= `IMF_POS_SYNC;
    end else begin
      pos_q <= pos_q + 4'h1;
    end
  end

  // Burst enable latched once, at the sync word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      burst_q <= 1'b0;
    end else if (pos_q == `IMF_POS_SYNC) begin
      burst_q <= usr.tx_burst_en;
    end
  end

  // Read request is decoded two slots ahead and asserted one cycle before the payload slot, to cover the user's register
  assign lead_pos = pos_q + `IMF_POS_PL_LEAD;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      usr.tx_pl_rd <= 1'b0;
    end else begin
      usr.tx_pl_rd <= burst_q && (lead_pos >= `IMF_POS_PL_FIRST) && (lead_pos <= `IMF_POS_PL_LAST);
    end
  end

  // Word builder
  always_comb begin
    hdr_d   = `IMF_HDR_CTRL;
    word_d  = `IMF_SKIP_WORD;
    ins_hdr = 1'b0;
    ins_crc = 1'b0;
    if (pos_q == `IMF_POS_SYNC) begin
      word_d = `IMF_SYNC_WORD;
    end else if (pos_q == `IMF_POS_SCRAM) begin
      word_d = `IMF_SCRAM_WORD;
    end else if (pos_q == `IMF_POS_DIAG) begin
      word_d = {`IMF_DIAG_TAG, usr.tx_diag_status, ~crc_q};
    end else if (pos_q >= `IMF_POS_PL_FIRST && burst_q) begin
      word_d  = usr.tx_pl_data;
      hdr_d   = usr.tx_pl_ctrl ? `IMF_HDR_CTRL : `IMF_HDR_DATA;
      // Only user payload slots reach here; sync, scrambler, skip and diag stay clean
      ins_hdr = usr.tx_err_ins && usr.cfg_simple_if;
      ins_crc = ins_hdr && usr.cfg_crc_err_en;
      if (ins_hdr) begin
        hdr_d = usr.tx_pl_ctrl ? `IMF_HDR_ERR_CTRL : `IMF_HDR_ERR_DATA;
      end
    end
    // Skip payload when burst is off: user data and error requests ignored
    crc_in = ins_crc ? ~word_d : word_d;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lane_tx_hdr  <= `IMF_HDR_CTRL;
      lane_tx_data <= `IMF_SKIP_WORD;
    end else begin
      lane_tx_hdr  <= hdr_d;
      lane_tx_data <= word_d;
    end
  end

  // CRC covers sync through last payload word; diag carries its complement
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crc_q <= `IMF_CRC_INIT;
    end else if (pos_q == `IMF_POS_SYNC) begin
      crc_q <= imf_pkg::imf_crc_step(`IMF_CRC_INIT, crc_in);
    end else if (pos_q != `IMF_POS_DIAG) begin
      crc_q <= imf_pkg::imf_crc_step(crc_q, crc_in);
    end
  end

  // Metaframe start stretched to three cycles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_cnt_q  <= 2'h0;
      usr.tx_frame <= 1'b0;
    end else if (pos_q == `IMF_POS_SYNC) begin
      frame_cnt_q  <= `IMF_STRETCH - 2'h1;
      usr.tx_frame <= 1'b1;
    end else begin
      frame_cnt_q  <= (frame_cnt_q != 2'h0) ? frame_cnt_q - 2'h1 : 2'h0;
      usr.tx_frame <= (frame_cnt_q != 2'h0);
    end
  end

  // DLL lock after a settling time from reset release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dll_cnt_q       <= '0;
      usr.tx_dll_lock <= 1'b0;
    end else if (dll_cnt_q != `IMF_DLL_CNT_W'(`IMF_DLL_LOCK_CYC)) begin
      dll_cnt_q <= dll_cnt_q + `IMF_DLL_CNT_W'(1);
    end else begin
      usr.tx_dll_lock <= 1'b1;
    end
  end

  // Receive frame synchroniser
  imf_pkg::imf_sync_state_e  state_q;
  logic [`IMF_POS_W-1:0]     rpos_q;
  logic [2:0]                good_q;
  logic [2:0]                bad_q;
  logic [31:0]               rcrc_q;
  logic [1:0]                rframe_cnt_q;
  logic [1:0]                crc_cnt_q;
  logic                      is_sync;
  logic                      at_start;
  logic                      diag_ok;

  assign is_sync  = (lane_rx_hdr == `IMF_HDR_CTRL) && (lane_rx_data == `IMF_SYNC_WORD);
  assign at_start = lane_rx_valid && is_sync && (state_q == imf_pkg::IMF_HUNT || rpos_q == `IMF_POS_SYNC);
  assign diag_ok  = lane_rx_valid && (state_q == imf_pkg::IMF_LOCKED) && (rpos_q == `IMF_POS_DIAG)
                    && (lane_rx_hdr == `IMF_HDR_CTRL) && (lane_rx_data[63:34] == `IMF_DIAG_TAG);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= imf_pkg::IMF_HUNT;
      rpos_q  <= `IMF_POS_SYNC;
      good_q  <= 3'h0;
      bad_q   <= 3'h0;
    end else if (lane_rx_valid) begin
      rpos_q <= rpos_q + 4'h1;
      unique case (state_q)
        imf_pkg::IMF_HUNT: begin
          rpos_q <= `IMF_POS_SCRAM;
          good_q <= 3'h1;
          bad_q  <= 3'h0;
          if (is_sync) begin
            state_q <= imf_pkg::IMF_VERIFY;
          end
        end
        imf_pkg::IMF_VERIFY: begin
          if (rpos_q == `IMF_POS_SYNC) begin
            if (!is_sync) begin
              state_q <= imf_pkg::IMF_HUNT;
            end else begin
              good_q <= good_q + 3'h1;
              if (good_q == `IMF_LOCK_GOOD - 3'h1) begin
                state_q <= imf_pkg::IMF_LOCKED;
              end
            end
          end
        end
        imf_pkg::IMF_LOCKED: begin
          if (rpos_q == `IMF_POS_SYNC) begin
            if (is_sync) begin
              bad_q <= 3'h0;
            end else if (bad_q == `IMF_LOSE_BAD - 3'h1) begin
              state_q <= imf_pkg::IMF_HUNT;
            end else begin
              bad_q <= bad_q + 3'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      usr.rx_frame_lock <= 1'b0;
    end else begin
      usr.rx_frame_lock <= (state_q == imf_pkg::IMF_LOCKED);
    end
  end

  // Received CRC, same coverage as the generator
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rcrc_q <= `IMF_CRC_INIT;
    end else if (at_start) begin
      rcrc_q <= imf_pkg::imf_crc_step(`IMF_CRC_INIT, lane_rx_data);
    end else if (lane_rx_valid && rpos_q != `IMF_POS_DIAG) begin
      rcrc_q <= imf_pkg::imf_crc_step(rcrc_q, lane_rx_data);
    end
  end

  // Status holds until the next good diag word under lock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      usr.rx_diag_status <= 2'h0;
    end else if (diag_ok) begin
      usr.rx_diag_status <= lane_rx_data[33:32];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crc_cnt_q                  <= 2'h0;
      usr.rx_metaframe_crc_error <= 1'b0;
    end else if (diag_ok && lane_rx_data[31:0] != ~rcrc_q) begin
      crc_cnt_q                  <= `IMF_STRETCH - 2'h1;
      usr.rx_metaframe_crc_error <= 1'b1;
    end else begin
      crc_cnt_q                  <= (crc_cnt_q != 2'h0) ? crc_cnt_q - 2'h1 : 2'h0;
      usr.rx_metaframe_crc_error <= (crc_cnt_q != 2'h0);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rframe_cnt_q <= 2'h0;
      usr.rx_frame <= 1'b0;
    end else if (at_start) begin
      rframe_cnt_q <= `IMF_STRETCH - 2'h1;
      usr.rx_frame <= 1'b1;
    end else begin
      rframe_cnt_q <= (rframe_cnt_q != 2'h0) ? rframe_cnt_q - 2'h1 : 2'h0;
      usr.rx_frame <= (rframe_cnt_q != 2'h0);
    end
  end

  // Payload delivery while locked
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      usr.rx_pl_valid <= 1'b0;
      usr.rx_pl_data  <= '0;
    end else begin
      usr.rx_pl_valid <= lane_rx_valid && (state_q == imf_pkg::IMF_LOCKED) && (lane_rx_hdr == `IMF_HDR_DATA)
                         && (rpos_q >= `IMF_POS_PL_FIRST) && (rpos_q <= `IMF_POS_PL_LAST);
      usr.rx_pl_data  <= lane_rx_data;
    end
  end

endmodule : imf_lane_framer

// [design/imf_lane_user.sv]
/*
  User-side lane controller: software registers, payload source, stable
  application of burst and lane status, error-insert requests, interrupts.
  Assumes the lane framer on imf_user_if.dev shares the clock.
*/
`timescale 1ns/1ps
`include "imf_cfg.svh"

module imf_lane_user (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  imf_user_if.usr                     lane,
  input  wire logic [`IMF_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output      logic [31:0]            rdata,
  output      logic                   irq
);

  logic [31:0]            ctrl_q;
  logic [2:0]             stat_q;
  logic [2:0]             mask_q;
  logic [2:0]             ev;
  logic [`IMF_POS_W-1:0]  since_q;
  logic                   frame_prev_q;
  logic                   lock_prev_q;
  logic                   crc_prev_q;
  logic                   err_pend_q;
  imf_pkg::imf_word_t     src_cnt_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= `IMF_CTRL_RST;
      mask_q <= 3'h0;
    end else if (wr && addr == `IMF_REG_CTRL) begin
      ctrl_q <= wdata;
    end else if (wr && addr == `IMF_REG_IRQ_MASK) begin
      mask_q <= wdata[2:0];
    end
  end

  // Cycles since the tx frame start rose; saturates
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      since_q      <= 4'h0;
      frame_prev_q <= 1'b0;
    end else begin
      frame_prev_q <= lane.tx_frame;
      if (lane.tx_frame && !frame_prev_q) begin
        since_q <= 4'h0;
      end else if (since_q != 4'hf) begin
        since_q <= since_q + 4'h1;
      end
    end
  end

  // Changes only mid-metaframe, well clear of the five-cycle hold on each side
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lane.tx_burst_en    <= 1'b0;
      lane.tx_diag_status <= 2'h0;
    end else if (since_q == `IMF_APPLY_AT) begin
      lane.tx_burst_en    <= ctrl_q[`IMF_CTRL_BURST];
      lane.tx_diag_status <= {ctrl_q[`IMF_CTRL_LANE_OK], ctrl_q[`IMF_CTRL_LINK_OK]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lane.cfg_simple_if  <= 1'b0;
      lane.cfg_crc_err_en <= 1'b0;
    end else begin
      lane.cfg_simple_if  <= ctrl_q[`IMF_CTRL_SIMPLE];
      lane.cfg_crc_err_en <= ctrl_q[`IMF_CTRL_CRC_ERR];
    end
  end

  // Payload source; counts on every read, data and ctrl zero until the tx DLL reports lock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      src_cnt_q       <= '0;
      lane.tx_pl_data <= '0;
      lane.tx_pl_ctrl <= 1'b0;
      lane.tx_err_ins <= 1'b0;
      err_pend_q      <= 1'b0;
    end else begin
      if (lane.tx_pl_rd) begin
        lane.tx_pl_data <= lane.tx_dll_lock ? src_cnt_q : '0;
        // Some control payload words, so both corrupted header codes can occur
        lane.tx_pl_ctrl <= lane.tx_dll_lock && src_cnt_q[2];
        src_cnt_q       <= src_cnt_q + 64'h0000_0000_0000_0001;
      end
      lane.tx_err_ins <= lane.tx_pl_rd && err_pend_q;
      // A new request in the consuming cycle stays pending
      if (wr && addr == `IMF_REG_CTRL && wdata[`IMF_CTRL_ERR_INS]) begin
        err_pend_q <= 1'b1;
      end else if (lane.tx_pl_rd) begin
        err_pend_q <= 1'b0;
      end
    end
  end

  // Interrupt events: set wins over write-one clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_prev_q <= 1'b0;
      crc_prev_q  <= 1'b0;
    end else begin
      lock_prev_q <= lane.rx_frame_lock;
      crc_prev_q  <= lane.rx_metaframe_crc_error;
    end
  end

  assign ev[`IMF_IRQ_CRC]       = lane.rx_metaframe_crc_error && !crc_prev_q;
  assign ev[`IMF_IRQ_LOCK_UP]   = lane.rx_frame_lock && !lock_prev_q;
  assign ev[`IMF_IRQ_LOCK_DOWN] = !lane.rx_frame_lock && lock_prev_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat_q <= 3'h0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr && addr == `IMF_REG_IRQ_STAT) ? wdata[2:0] : 3'h0)) | ev;
      irq    <= |(stat_q & mask_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        `IMF_REG_CTRL:     rdata <= ctrl_q & 32'h0000_001f;
        `IMF_REG_STATUS:   rdata <= {28'h000_0000, lane.rx_diag_status, lane.rx_frame_lock, lane.tx_dll_lock};
        `IMF_REG_IRQ_STAT: rdata <= {29'h0000_0000, stat_q};
        `IMF_REG_IRQ_MASK: rdata <= {29'h0000_0000, mask_q};
        default:           rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule : imf_lane_user

// [verification/imf_framer_asserts.sv]
/* Timing checks on the framer user interface.
   Assumes the bench wires the interface signals in by name. */
`timescale 1ns/1ps
module imf_framer_asserts (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       tx_frame,
  input wire logic       tx_dll_lock,
  input wire logic       tx_pl_rd,
  input wire logic [1:0] tx_diag_status,
  input wire logic       tx_burst_en,
  input wire logic       rx_frame,
  input wire logic       rx_frame_lock,
  input wire logic [1:0] rx_diag_status,
  input wire logic       rx_metaframe_crc_error
);
  localparam logic [4:0] RD_FULL = 5'h0c;
  logic       fr_q;
  logic       burst_q;
  logic       armed_q;
  logic [4:0] rd_cnt_q;
  wire        rise = tx_frame && !fr_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Reads per metaframe; first window unarmed, its burst is unknown
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fr_q     <= 1'b0;
      armed_q  <= 1'b0;
      burst_q  <= 1'b0;
      rd_cnt_q <= 5'h00;
    end else begin
      fr_q <= tx_frame;
      if (rise) begin
        armed_q  <= 1'b1;
        burst_q  <= tx_burst_en;
        rd_cnt_q <= {4'h0, tx_pl_rd};
      end else begin
        rd_cnt_q <= rd_cnt_q + {4'h0, tx_pl_rd};
      end
    end
  end

  tx_start_len_a: assert property ($rose(tx_frame) |-> tx_frame [*3] ##1 !tx_frame)
    else $error("tx frame start not three cycles");
  frame_period_a: assert property ($rose(tx_frame) |-> ##16 $rose(tx_frame))
    else $error("tx metaframe period wrong");
  status_hold_a: assert property ($rose(tx_frame) |->
    (tx_diag_status == $past(tx_diag_status, 5)) ##0 $stable(tx_diag_status) [*6])
    else $error("tx lane status moved near frame start");
  burst_hold_a: assert property ($rose(tx_frame) |->
    (tx_burst_en == $past(tx_burst_en, 5)) ##0 $stable(tx_burst_en) [*6])
    else $error("burst enable moved near frame start");
  read_count_a: assert property (rise && armed_q |-> rd_cnt_q == (burst_q ? RD_FULL : 5'h00))
    else $error("payload read count wrong for metaframe");
  rx_start_len_a: assert property ($rose(rx_frame) |-> rx_frame [*3] ##1 !rx_frame)
    else $error("rx frame start not three cycles");
  crc_err_len_a: assert property ($rose(rx_metaframe_crc_error) |->
    rx_metaframe_crc_error [*3] ##1 !rx_metaframe_crc_error)
    else $error("crc error pulse not three cycles");
  lock_hold_a: assert property ($rose(rx_frame_lock) |-> rx_frame_lock [*8])
    else $error("frame lock dropped right after gain");
  rx_status_hold_a: assert property (!rx_frame_lock |=> $stable(rx_diag_status))
    else $error("rx status changed without lock");
  dll_stay_a: assert property (tx_dll_lock |=> tx_dll_lock)
    else $error("tx dll lock dropped");

  cover property ($rose(rx_metaframe_crc_error));
  cover property ($rose(rx_frame_lock));
  cover property (rise && armed_q && !burst_q);
endmodule : imf_framer_asserts

// [verification/interlaken_metaframe_framer_bench.sv]
/* Loopback bench: framer transmit feeds its own receive; user controller
   driven over its register port. Assumes the design files compiled first. */
`timescale 1ns/1ps
`include "imf_cfg.svh"
module interlaken_metaframe_framer_bench;
  typedef struct packed {
    logic [1:0] st;
    logic       burst;
    logic       hdr_err;
    logic       crc_bad;
  } imf_note_s;
  logic                   clock;
  logic                   rst_n;
  logic [`IMF_ADDR_W-1:0] addr;
  logic [31:0]            wdata;
  logic                   wr;
  logic                   rd;
  logic [31:0]            rdata;
  logic                   irq;
  logic [1:0]             tx_hdr;
  imf_pkg::imf_word_t     tx_data;
  int                     fail_count = 0;
  int                     checked = 0;
  int                     pos = 99;
  int                     herr = 0;
  logic [31:0]            crc;
  logic                   rd_seen = 1'b0;
  logic                   rx_pend = 1'b0;
  logic                   pv = 1'b0;
  imf_pkg::imf_word_t     prev_tx;
  imf_note_s              cur;
  imf_note_s              nq[$];
  logic [31:0]            rq[$];

  imf_user_if lane_link ();
  imf_lane_framer imf_lane_framer_inst (.clock(clock), .rst_n(rst_n), .usr(lane_link), .lane_tx_hdr(tx_hdr),
    .lane_tx_data(tx_data), .lane_rx_valid(1'b1), .lane_rx_hdr(tx_hdr), .lane_rx_data(tx_data));
  imf_lane_user imf_lane_user_inst (.clock(clock), .rst_n(rst_n), .lane(lane_link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  imf_framer_asserts imf_framer_asserts_inst (.clock(clock), .rst_n(rst_n), .tx_frame(lane_link.tx_frame),
    .tx_dll_lock(lane_link.tx_dll_lock), .tx_pl_rd(lane_link.tx_pl_rd), .tx_burst_en(lane_link.tx_burst_en),
    .tx_diag_status(lane_link.tx_diag_status), .rx_frame(lane_link.rx_frame),
    .rx_frame_lock(lane_link.rx_frame_lock), .rx_diag_status(lane_link.rx_diag_status),
    .rx_metaframe_crc_error(lane_link.rx_metaframe_crc_error));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Leading edge keeps back-to-back calls from driving a strobe twice at once
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    rq.push_back(exp);
    @(posedge clock);
    rd <= 1'b0;
  endtask : reg_rd

  task automatic wait_until(input int lim, input bit lock);
    int n;
    n = 0;
    while (n < lim && (lock ? lane_link.rx_frame_lock !== 1'b1 : lane_link.tx_frame !== 1'b0)) begin
      @(posedge clock);
      n++;
    end
    while (!lock && n < lim && lane_link.tx_frame !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      conclude();
    end
  endtask : wait_until

  function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [63:0] d);
    logic fb;
    for (int i = 63; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c  = c << 1;
      if (fb) c = c ^ `IMF_CRC_POLY;
    end
    return c;
  endfunction : crc_next

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Watcher: words are located by the sync word, not by tx_frame timing
  always @(posedge clock) begin
    if (rst_n) check(32'(lane_link.rx_pl_valid), 32'(pv), "rx valid");
    if (rst_n && pv) check(lane_link.rx_pl_data[31:0], prev_tx[31:0], "rx payload");
    if (rx_pend) begin
      check(32'(lane_link.rx_diag_status), 32'(cur.st), "rx status");
      check(32'(lane_link.rx_metaframe_crc_error), 32'(cur.crc_bad), "rx crc error");
      rx_pend = 1'b0;
    end
    if (rd_seen) check(rdata, rq.pop_front(), "rdata");
    rd_seen = rd;
    if (tx_hdr == `IMF_HDR_CTRL && tx_data == `IMF_SYNC_WORD) begin
      pos  = 0;
      crc  = `IMF_CRC_INIT;
      herr = 0;
    end else if (pos < 16) pos++;
    if (pos <= 14) crc = crc_next(crc, tx_data);
    if (pos >= 3 && pos <= 14) herr += int'(tx_hdr == (tx_data[2] ? `IMF_HDR_ERR_CTRL : `IMF_HDR_ERR_DATA));
    if (nq.size() > 0 && pos >= 1 && pos <= 15) begin
      if (pos <= 2 || pos == 15 || !nq[0].burst) check(32'(tx_hdr), 32'(`IMF_HDR_CTRL), "ctrl hdr");
      if (pos >= 3 && pos <= 14 && !nq[0].burst) check(tx_data[31:0], 32'(`IMF_SKIP_WORD), "skip");
    end
    if (pos == 15 && nq.size() > 0) begin
      cur = nq.pop_front();
      check(32'(tx_data[63:34]), 32'(`IMF_DIAG_TAG), "diag tag");
      check(32'(tx_data[33:32]), 32'(cur.st), "diag status");
      check(32'(tx_data[31:0] !== ~crc), 32'(cur.crc_bad), "diag crc");
      check(32'(herr), 32'(cur.hdr_err), "hdr errors");
      rx_pend = 1'b1;
    end
    pv      = lane_link.rx_frame_lock && tx_hdr == `IMF_HDR_DATA && pos >= 3 && pos <= 14;
    prev_tx = tx_data;
  end

  initial begin
    logic [1:0] st;
    logic       burst;
    logic       nb;
    logic       err;
    rst_n = 1'b0;
    addr  = 4'h0;
    wdata = 32'h0000_0000;
    wr    = 1'b0;
    rd    = 1'b0;
    void'($urandom(32'h6131));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    reg_rd(`IMF_REG_CTRL, 32'h0000_0001);
    reg_rd(4'h2, 32'h0000_0000);
    reg_rd(`IMF_REG_IRQ_MASK, 32'h0000_0000);
    reg_wr(`IMF_REG_CTRL, 32'h0000_0007);
    wait_until(400, 1'b1);
    burst = 1'b1;
    // Error requests only with burst on; otherwise they wait for a later frame
    for (int i = 0; i < 16; i++) begin
      st  = 2'($urandom);
      nb  = (i % 3 != 1);
      err = i[2] && burst;
      wait_until(40, 1'b0);
      @(posedge clock);
      nq.push_back('{st: st, burst: burst, hdr_err: err && i[0], crc_bad: err && i[0] && i[1]});
      reg_wr(`IMF_REG_CTRL, {26'h000_0000, err, i[1], i[0], st[0], st[1], nb});
      burst = nb;
    end
    wait_until(40, 1'b0);
    wait_until(40, 1'b0);
    reg_rd(`IMF_REG_STATUS, {28'h000_0000, st, 2'b11});
    reg_rd(`IMF_REG_IRQ_STAT, 32'h0000_0003);
    check(32'(irq), 32'h0000_0000, "irq masked");
    reg_wr(`IMF_REG_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0000_0001, "irq raised");
    reg_wr(`IMF_REG_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0000_0000, "irq cleared");
    reg_rd(`IMF_REG_IRQ_STAT, 32'h0000_0002);
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule : interlaken_metaframe_framer_bench
